/* rtl/config_set_regs.svh */
// constants for the configuration set manager
// Behaviour
// - shipped default-set choice is the standard factory setup
// - default-set choice takes one of four fixed factory setups
// - default-set choice changes only while no acquisition runs or is pending
// - load source is user set 1, 2, 3 or the default set
// - load command copies the selected stored set over the active set
// - load command runs only while no acquisition runs or is pending
// - loading the default set copies the currently chosen factory setup
// - startup set is user set 1, 2, 3 or the default set
// - after power-on and every reset the startup set is loaded
// - feature-set choice is full or basic and survives power-off
// - a new feature-set choice applies only after the next reset or power cycle
// - basic set hides colour matrix, colour adjustment and sequencer
// - features become ready sooner with the basic set than the full set
// - enabled per-image information is appended to each acquired image
// - nothing is appended while trailing info mode is off
// - frame-count stamp carries the acquired-image counter value
// - active set is volatile and lost on reset or power loss
// - save writes the active set over the chosen user set
`ifndef CONFIG_SET_REGS_SVH
`define CONFIG_SET_REGS_SVH

// ----------------------------------------------------------------
// set geometry and nonvolatile map
// ----------------------------------------------------------------
`define SET_WORDS        8
`define WORD_IDX_W       3
`define PARAM_W          16
`define NV_ADDR_W        5
`define NV_FACTORY_ADDR  5'h18
`define NV_FEATURE_ADDR  5'h19
`define NV_STARTUP_ADDR  5'h1A
`define NV_BLANK_WORD    16'hFFFF
`define FRAME_CNT_W      32

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FACTORY      2'h0
`define RST_STARTUP      2'h3
`define RST_FEATURE      1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS   25
`define BASIC_READY_NS   400
`define FULL_READY_NS    1600
`define BASIC_READY_CYC  ((`BASIC_READY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define FULL_READY_CYC   ((`FULL_READY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define READY_CNT_W      7

`endif

/* rtl/config_set_pkg.sv */
// types for the configuration set manager
package config_set_pkg;

    typedef enum logic [1:0]
    {
        FAC_STANDARD  = 2'h0,
        FAC_HIGH_GAIN = 2'h1,
        FAC_AUTO      = 2'h2,
        FAC_COLOUR    = 2'h3
    } factory_e;

    typedef enum logic [1:0]
    {
        SET_USER1   = 2'h0,
        SET_USER2   = 2'h1,
        SET_USER3   = 2'h2,
        SET_DEFAULT = 2'h3
    } stored_e;

    typedef enum logic [2:0]
    {
        ST_BOOT = 3'h0,
        ST_LOAD = 3'h1,
        ST_SAVE = 3'h2,
        ST_PWR  = 3'h3,
        ST_IDLE = 3'h4
    } state_e;

endpackage : config_set_pkg

/* rtl/factory_setup_rom.sv */
// fixed factory setups, registered read
`timescale 1ns/1ps
`default_nettype none
`include "config_set_regs.svh"

module factory_setup_rom
    import config_set_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic [1:0]              setupSel,
    input  wire logic [`WORD_IDX_W-1:0]  wordIdx,
    output var  logic [`PARAM_W-1:0]     romData
);

    logic [`PARAM_W-1:0] nxt_romData;

    // ----------------------------------------------------------------
    // contents: word 0 gain, word 1 auto flags, word 2 colour mode
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_romData = 16'h0000;
        unique case (wordIdx)
            3'h0:    nxt_romData = (setupSel == FAC_HIGH_GAIN) ? 16'h0040 : 16'h0010;
            3'h1:    nxt_romData = (setupSel == FAC_AUTO) ? 16'h0003 : 16'h0000;
            3'h2:    nxt_romData = (setupSel == FAC_COLOUR) ? 16'h0001 : 16'h0000;
            default: nxt_romData = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        romData <= nxt_romData;
    end

endmodule : factory_setup_rom
`default_nettype wire

/* rtl/active_set_ram.sv */
// volatile active parameter set, registered read
`timescale 1ns/1ps
`default_nettype none
`include "config_set_regs.svh"

module active_set_ram
(
    input  wire logic                    mclk,
    input  wire logic                    wrEn,
    input  wire logic [`WORD_IDX_W-1:0]  wrAddr,
    input  wire logic [`PARAM_W-1:0]     wrData,
    input  wire logic [`WORD_IDX_W-1:0]  rdAddr,
    output var  logic [`PARAM_W-1:0]     rdData
);

    logic [`PARAM_W-1:0] mem [`SET_WORDS];

    // ----------------------------------------------------------------
    // storage, no reset: contents are undefined until loaded
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule : active_set_ram
`default_nettype wire

/* rtl/config_set_manager.sv */
// configuration set manager: startup load, set loads and saves, feature set, chunk gate
`timescale 1ns/1ps
`default_nettype none
`include "config_set_regs.svh"

module config_set_manager
    import config_set_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    acqRunning,
    input  wire logic                    acqPending,
    input  wire logic                    factoryDefaultWr,
    input  wire logic [1:0]              factoryDefaultChoice,
    input  wire logic [1:0]              storedSetChoice,
    input  wire logic                    loadStoredSetCmd,
    input  wire logic                    saveStoredSetCmd,
    input  wire logic                    startupSetWr,
    input  wire logic [1:0]              startupSetChoice,
    input  wire logic                    featureDescWr,
    input  wire logic                    featureDescriptionChoice,
    input  wire logic                    trailingInfoEnable,
    input  wire logic                    frameCountChunkEn,
    input  wire logic                    frameCaptured,
    input  wire logic [`FRAME_CNT_W-1:0] frameCount,
    input  wire logic                    paramWr,
    input  wire logic [`WORD_IDX_W-1:0]  paramAddr,
    input  wire logic [`PARAM_W-1:0]     paramWdata,
    output var  logic [`PARAM_W-1:0]     paramRdata,
    output var  logic                    nvRdEn,
    output var  logic                    nvWrEn,
    output var  logic [`NV_ADDR_W-1:0]   nvAddr,
    output var  logic [`PARAM_W-1:0]     nvWdata,
    input  wire logic [`PARAM_W-1:0]     nvRdata,
    input  wire logic                    nvDone,
    output var  logic                    busy,
    output var  logic                    cmdRefused,
    output var  logic [1:0]              factoryDefaultSel,
    output var  logic [1:0]              startupSetSel,
    output var  logic                    featureDescStored,
    output var  logic                    featureFullActive,
    output var  logic                    colourMatrixAvail,
    output var  logic                    colourAdjustAvail,
    output var  logic                    sequencerAvail,
    output var  logic                    featuresReady,
    output var  logic                    chunkValid,
    output var  logic [`FRAME_CNT_W-1:0] chunkFrameCount
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [`NV_ADDR_W-1:0] userAddr(input logic [1:0] set,
                                                      input logic [`WORD_IDX_W-1:0] idx);
        userAddr = {set, idx};
    endfunction : userAddr

    function automatic logic [`READY_CNT_W-1:0] readyLimit(input logic full);
        readyLimit = full ? `READY_CNT_W'(`FULL_READY_CYC) : `READY_CNT_W'(`BASIC_READY_CYC);
    endfunction : readyLimit

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_e                   state_ff,    nxt_state;
    logic [`WORD_IDX_W-1:0]   idx_ff,      nxt_idx;
    logic [1:0]               phase_ff,    nxt_phase;
    logic [1:0]               loadSrc_ff,  nxt_loadSrc;
    logic [1:0]               saveSet_ff,  nxt_saveSet;
    logic [1:0]               factory_ff,  nxt_factory;
    logic [1:0]               startup_ff,  nxt_startup;
    logic                     featStor_ff, nxt_featStor;
    logic                     featAct_ff,  nxt_featAct;
    logic                     nvRd_ff,     nxt_nvRd;
    logic                     nvWr_ff,     nxt_nvWr;
    logic [`NV_ADDR_W-1:0]    nvAddr_ff,   nxt_nvAddr;
    logic [`PARAM_W-1:0]      nvWdata_ff,  nxt_nvWdata;
    logic                     refused_ff,  nxt_refused;
    logic [`READY_CNT_W-1:0]  readyCnt_ff, nxt_readyCnt;
    logic                     ready_ff,    nxt_ready;
    logic                     chunk_ff,    nxt_chunk;
    logic [`FRAME_CNT_W-1:0]  stamp_ff,    nxt_stamp;

    logic                     ramWe;
    logic [`PARAM_W-1:0]      ramWdata;
    logic [`WORD_IDX_W-1:0]   ramRaddr;
    logic [`PARAM_W-1:0]      ramRdata;
    logic [`PARAM_W-1:0]      romData;
    logic                     acqIdle;
    logic                     anyCmd;
    logic                     lastWord;

    assign acqIdle  = !acqRunning && !acqPending;
    assign anyCmd   = loadStoredSetCmd || saveStoredSetCmd || factoryDefaultWr
                   || startupSetWr || featureDescWr;
    assign lastWord = (idx_ff == `WORD_IDX_W'(`SET_WORDS - 1));

    // ----------------------------------------------------------------
    // memories
    // ----------------------------------------------------------------
    active_set_ram u_active (
        .mclk   (mclk),
        .wrEn   (ramWe),
        .wrAddr (ramWe && (state_ff != ST_IDLE) ? idx_ff : paramAddr),
        .wrData (ramWdata),
        .rdAddr (ramRaddr),
        .rdData (ramRdata)
    );

    factory_setup_rom u_rom (
        .mclk     (mclk),
        .setupSel (factory_ff),
        .wordIdx  (idx_ff),
        .romData  (romData)
    );

    // ----------------------------------------------------------------
    // sequencer: next values
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_idx     = idx_ff;
        nxt_phase   = phase_ff;
        nxt_loadSrc = loadSrc_ff;
        nxt_saveSet = saveSet_ff;
        nxt_factory = factory_ff;
        nxt_startup = startup_ff;
        nxt_featStor = featStor_ff;
        nxt_featAct = featAct_ff;
        nxt_nvRd    = nvRd_ff;
        nxt_nvWr    = nvWr_ff;
        nxt_nvAddr  = nvAddr_ff;
        nxt_nvWdata = nvWdata_ff;
        nxt_refused = 1'b0;
        ramWe       = 1'b0;
        ramWdata    = paramWdata;
        ramRaddr    = (state_ff == ST_SAVE) ? idx_ff : paramAddr;
        unique case (state_ff)
            ST_BOOT:
            begin
                // read factory choice, feature choice, startup choice in turn
                if (phase_ff == 2'h0)
                begin
                    nxt_nvRd   = 1'b1;
                    nxt_nvAddr = `NV_FACTORY_ADDR + `NV_ADDR_W'(idx_ff);
                    nxt_phase  = 2'h1;
                end
                else if (nvDone)
                begin
                    nxt_nvRd  = 1'b0;
                    nxt_phase = 2'h0;
                    nxt_idx   = idx_ff + 3'h1;
                    if (idx_ff == 3'h0)
                    begin
                        nxt_factory = (nvRdata == `NV_BLANK_WORD) ? `RST_FACTORY
                                                                  : nvRdata[1:0];
                    end
                    else if (idx_ff == 3'h1)
                    begin
                        nxt_featStor = (nvRdata == `NV_BLANK_WORD) ? `RST_FEATURE
                                                                   : nvRdata[0];
                        nxt_featAct  = nxt_featStor;
                    end
                    else
                    begin
                        nxt_startup = (nvRdata == `NV_BLANK_WORD) ? `RST_STARTUP
                                                                  : nvRdata[1:0];
                        nxt_loadSrc = nxt_startup;
                        nxt_idx     = 3'h0;
                        nxt_state   = ST_LOAD;
                    end
                end
            end
            ST_LOAD:
            begin
                if (phase_ff == 2'h0)
                begin
                    if (loadSrc_ff != SET_DEFAULT)
                    begin
                        nxt_nvRd   = 1'b1;
                        nxt_nvAddr = userAddr(loadSrc_ff, idx_ff);
                    end
                    nxt_phase = 2'h1;
                end
                else if ((loadSrc_ff == SET_DEFAULT) || nvDone)
                begin
                    ramWe     = 1'b1;
                    ramWdata  = (loadSrc_ff == SET_DEFAULT) ? romData : nvRdata;
                    nxt_nvRd  = 1'b0;
                    nxt_phase = 2'h0;
                    nxt_idx   = idx_ff + 3'h1;
                    if (lastWord)
                    begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_SAVE:
            begin
                if (phase_ff == 2'h0)
                begin
                    nxt_phase = 2'h1;
                end
                else if (phase_ff == 2'h1)
                begin
                    nxt_nvWr    = 1'b1;
                    nxt_nvAddr  = userAddr(saveSet_ff, idx_ff);
                    nxt_nvWdata = ramRdata;
                    nxt_phase   = 2'h2;
                end
                else if (nvDone)
                begin
                    nxt_nvWr  = 1'b0;
                    nxt_phase = 2'h0;
                    nxt_idx   = idx_ff + 3'h1;
                    if (lastWord)
                    begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_PWR:
            begin
                if (nvDone)
                begin
                    nxt_nvWr  = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                nxt_idx   = 3'h0;
                nxt_phase = 2'h0;
                ramWe     = paramWr;
                if (loadStoredSetCmd && acqIdle)
                begin
                    nxt_loadSrc = storedSetChoice;
                    nxt_state   = ST_LOAD;
                end
                else if (saveStoredSetCmd && (storedSetChoice != SET_DEFAULT))
                begin
                    nxt_saveSet = storedSetChoice;
                    nxt_state   = ST_SAVE;
                end
                else if (factoryDefaultWr && acqIdle)
                begin
                    nxt_factory = factoryDefaultChoice;
                    nxt_nvWr    = 1'b1;
                    nxt_nvAddr  = `NV_FACTORY_ADDR;
                    nxt_nvWdata = {14'h0000, factoryDefaultChoice};
                    nxt_state   = ST_PWR;
                end
                else if (startupSetWr)
                begin
                    nxt_startup = startupSetChoice;
                    nxt_nvWr    = 1'b1;
                    nxt_nvAddr  = `NV_STARTUP_ADDR;
                    nxt_nvWdata = {14'h0000, startupSetChoice};
                    nxt_state   = ST_PWR;
                end
                else if (featureDescWr)
                begin
                    nxt_featStor = featureDescriptionChoice;
                    nxt_nvWr     = 1'b1;
                    nxt_nvAddr   = `NV_FEATURE_ADDR;
                    nxt_nvWdata  = {15'h0000, featureDescriptionChoice};
                    nxt_state    = ST_PWR;
                end
                else
                begin
                    nxt_refused = anyCmd;
                end
                if (anyCmd && (nxt_state == ST_IDLE))
                begin
                    nxt_refused = 1'b1;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if ((state_ff != ST_IDLE) && anyCmd)
        begin
            nxt_refused = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // readiness timer, chunk gate
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_readyCnt = readyCnt_ff;
        nxt_ready    = ready_ff;
        if (!ready_ff && (state_ff != ST_BOOT))
        begin
            nxt_readyCnt = readyCnt_ff + `READY_CNT_W'(1);
            nxt_ready    = (nxt_readyCnt >= readyLimit(featAct_ff));
        end
        nxt_chunk = frameCaptured && trailingInfoEnable && frameCountChunkEn;
        nxt_stamp = nxt_chunk ? frameCount : stamp_ff;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_BOOT;
            idx_ff      <= 3'h0;
            phase_ff    <= 2'h0;
            loadSrc_ff  <= `RST_STARTUP;
            saveSet_ff  <= 2'h0;
            factory_ff  <= `RST_FACTORY;
            startup_ff  <= `RST_STARTUP;
            featStor_ff <= `RST_FEATURE;
            featAct_ff  <= `RST_FEATURE;
            nvRd_ff     <= 1'b0;
            nvWr_ff     <= 1'b0;
            nvAddr_ff   <= 5'h00;
            nvWdata_ff  <= 16'h0000;
            refused_ff  <= 1'b0;
            readyCnt_ff <= 7'h00;
            ready_ff    <= 1'b0;
            chunk_ff    <= 1'b0;
            stamp_ff    <= 32'h0000_0000;
        end
        else
        begin
            state_ff    <= nxt_state;
            idx_ff      <= nxt_idx;
            phase_ff    <= nxt_phase;
            loadSrc_ff  <= nxt_loadSrc;
            saveSet_ff  <= nxt_saveSet;
            factory_ff  <= nxt_factory;
            startup_ff  <= nxt_startup;
            featStor_ff <= nxt_featStor;
            featAct_ff  <= nxt_featAct;
            nvRd_ff     <= nxt_nvRd;
            nvWr_ff     <= nxt_nvWr;
            nvAddr_ff   <= nxt_nvAddr;
            nvWdata_ff  <= nxt_nvWdata;
            refused_ff  <= nxt_refused;
            readyCnt_ff <= nxt_readyCnt;
            ready_ff    <= nxt_ready;
            chunk_ff    <= nxt_chunk;
            stamp_ff    <= nxt_stamp;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign paramRdata        = ramRdata;
    assign nvRdEn            = nvRd_ff;
    assign nvWrEn            = nvWr_ff;
    assign nvAddr            = nvAddr_ff;
    assign nvWdata           = nvWdata_ff;
    assign busy              = (state_ff != ST_IDLE);
    assign cmdRefused        = refused_ff;
    assign factoryDefaultSel = factory_ff;
    assign startupSetSel     = startup_ff;
    assign featureDescStored = featStor_ff;
    assign featureFullActive = featAct_ff;
    assign colourMatrixAvail = featAct_ff && ready_ff;
    assign colourAdjustAvail = featAct_ff && ready_ff;
    assign sequencerAvail    = featAct_ff && ready_ff;
    assign featuresReady     = ready_ff;
    assign chunkValid        = chunk_ff;
    assign chunkFrameCount   = stamp_ff;

endmodule : config_set_manager
`default_nettype wire

/* dv/config_set_manager_checker.sv */
// assertion checker for the configuration set manager
`timescale 1ns/1ps
`default_nettype none
`include "config_set_regs.svh"
module config_set_manager_checker (
    input wire logic mclk, rst_n, acqRunning, acqPending, factoryDefaultWr, loadStoredSetCmd,
    input wire logic saveStoredSetCmd, trailingInfoEnable, frameCountChunkEn, frameCaptured,
    input wire logic nvRdEn, nvDone, busy, cmdRefused, featureFullActive, featuresReady,
    input wire logic colourMatrixAvail, colourAdjustAvail, sequencerAvail, chunkValid,
    input wire logic [1:0] factoryDefaultSel,
    input wire logic [`NV_ADDR_W-1:0] nvAddr,
    input wire logic [`FRAME_CNT_W-1:0] frameCount, chunkFrameCount
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence acqBusy;
        acqRunning || acqPending;
    endsequence
    load_go_a:
        assert property (loadStoredSetCmd && !busy && !acqRunning && !acqPending
            |=> busy && !cmdRefused) else $error("load not started");
    load_refuse_a:
        assert property (loadStoredSetCmd && !busy ##0 acqBusy |=> cmdRefused && !busy)
            else $error("load during acquisition accepted");
    fac_refuse_a:
        assert property (factoryDefaultWr && !busy && !loadStoredSetCmd && !saveStoredSetCmd
            ##0 acqBusy |=> cmdRefused && $stable(factoryDefaultSel))
            else $error("default choice changed during acquisition");
    chunk_stamp_a:
        assert property (frameCaptured && trailingInfoEnable && frameCountChunkEn
            |=> chunkValid && chunkFrameCount == $past(frameCount)) else $error("bad stamp");
    chunk_gate_a:
        assert property (chunkValid |-> $past(frameCaptured) && $past(trailingInfoEnable))
            else $error("chunk without capture or mode");
    nv_hold_a:
        assert property (nvRdEn && !nvDone |=> nvRdEn && $stable(nvAddr))
            else $error("store read dropped early");
    basic_hide_a:
        assert property (colourMatrixAvail || colourAdjustAvail || sequencerAvail
            |-> featureFullActive && featuresReady) else $error("colour feature in basic set");
    full_show_a:
        assert property (featureFullActive && featuresReady
            |-> colourMatrixAvail && colourAdjustAvail && sequencerAvail)
            else $error("full set feature missing");
    feat_hold_a:
        assert property (!busy |-> $stable(featureFullActive)) else $error("feature set moved");
endmodule : config_set_manager_checker
bind config_set_manager config_set_manager_checker chk (.*);
`default_nettype wire

/* dv/config_set_manager_tb_top.sv */
// self-checking testbench for the configuration set manager
`timescale 1ns/1ps
`default_nettype none
`include "config_set_regs.svh"
module config_set_manager_tb_top;
    import config_set_pkg::*;
    logic mclk, rst_n, acqRunning, acqPending, factoryDefaultWr, loadStoredSetCmd;
    logic saveStoredSetCmd, startupSetWr, featureDescWr, featureDescriptionChoice, nvDone;
    logic trailingInfoEnable, frameCountChunkEn, frameCaptured, paramWr, nvRdEn, nvWrEn, busy;
    logic cmdRefused, featureDescStored, featureFullActive, colourMatrixAvail, chunkValid;
    logic colourAdjustAvail, sequencerAvail, featuresReady;
    logic [1:0] factoryDefaultChoice, storedSetChoice, startupSetChoice;
    logic [1:0] factoryDefaultSel, startupSetSel;
    logic [2:0] paramAddr;
    logic [4:0] nvAddr;
    logic [15:0] paramWdata, paramRdata, nvWdata, nvRdata;
    logic [31:0] frameCount, chunkFrameCount;
    logic [15:0] nvMem [32];
    int fail_count, n_checks;
    config_set_manager uut (.*);
    initial
    begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    // nonvolatile store: answers each access one cycle later
    always @(negedge mclk)
    begin
        nvDone <= (nvRdEn || nvWrEn) && !nvDone;
        nvRdata <= nvMem[nvAddr] ^ {16{nvDone}};
        if (nvWrEn && !nvDone) nvMem[nvAddr] <= nvWdata;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic idle();
        int i;
        for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk);
        chk(busy, 0);
    endtask : idle
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        paramAddr = a;
        repeat (3) @(negedge mclk);
        chk(paramRdata, exp);
    endtask : rd
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic t_boot();
        idle();
        chk(factoryDefaultSel, FAC_STANDARD);
        chk(startupSetSel, SET_DEFAULT);
        rd(0, 16'h0010);
        chk(featuresReady, 1);
        $display("boot done");
    endtask : t_boot
    task automatic t_factory();
        for (int f = 3; f >= 1; f--)
        begin
            factoryDefaultChoice = f[1:0]; factoryDefaultWr = 1; @(negedge mclk);
            factoryDefaultWr = 0; idle();
            chk(factoryDefaultSel, f);
        end
        storedSetChoice = SET_DEFAULT; loadStoredSetCmd = 1; @(negedge mclk);
        loadStoredSetCmd = 0; idle();
        rd(0, 16'h0040);
        acqRunning = 1; loadStoredSetCmd = 1; @(negedge mclk);
        loadStoredSetCmd = 0; chk({cmdRefused, busy}, 2'h2);
        acqRunning = 0; acqPending = 1; factoryDefaultChoice = 0; factoryDefaultWr = 1;
        @(negedge mclk); factoryDefaultWr = 0; acqPending = 0;
        chk({cmdRefused, factoryDefaultSel}, 3'h5);
        $display("factory done");
    endtask : t_factory
    task automatic t_user();
        paramAddr = 0; paramWdata = 16'h1234; paramWr = 1; @(negedge mclk); paramWr = 0;
        storedSetChoice = SET_USER2; saveStoredSetCmd = 1; @(negedge mclk);
        saveStoredSetCmd = 0; idle();
        chk(nvMem[5'h08], 16'h1234);
        storedSetChoice = SET_DEFAULT; loadStoredSetCmd = 1; @(negedge mclk);
        loadStoredSetCmd = 0; idle();
        storedSetChoice = SET_USER2; loadStoredSetCmd = 1; @(negedge mclk);
        loadStoredSetCmd = 0; idle();
        rd(0, 16'h1234);
        $display("user done");
    endtask : t_user
    task automatic t_chunk();
        trailingInfoEnable = 1; frameCountChunkEn = 1; frameCount = 32'hA5; frameCaptured = 1;
        @(negedge mclk); frameCaptured = 0;
        chk(chunkValid, 1);
        chk(chunkFrameCount, 32'hA5);
        trailingInfoEnable = 0; frameCaptured = 1; @(negedge mclk); frameCaptured = 0;
        chk(chunkValid, 0);
        chk(chunkFrameCount, 32'hA5);
        $display("chunk done");
    endtask : t_chunk
    task automatic t_feature();
        featureDescriptionChoice = 1; featureDescWr = 1; @(negedge mclk); featureDescWr = 0;
        idle();
        startupSetChoice = SET_USER2; startupSetWr = 1; @(negedge mclk); startupSetWr = 0;
        idle();
        chk(startupSetSel, SET_USER2);
        chk({featureDescStored, featureFullActive}, 2'h2);
        paramAddr = 0; paramWdata = 16'h5A5A; paramWr = 1; @(negedge mclk); paramWr = 0;
        rst_n = 0; repeat (2) @(negedge mclk); rst_n = 1;
        idle();
        chk(featuresReady, 0);
        repeat (70) @(negedge mclk);
        chk({featureFullActive, colourMatrixAvail}, 2'h3);
        rd(0, 16'h1234);
        $display("feature done");
    endtask : t_feature
    initial
    begin
        foreach (nvMem[i]) nvMem[i] = 16'hFFFF;
        {rst_n, acqRunning, acqPending, factoryDefaultWr, loadStoredSetCmd, saveStoredSetCmd,
            startupSetWr, featureDescWr, featureDescriptionChoice, trailingInfoEnable} = '0;
        {frameCountChunkEn, frameCaptured, paramWr, factoryDefaultChoice} = '0;
        {storedSetChoice, startupSetChoice, paramAddr, paramWdata, frameCount} = '0;
        repeat (16) @(negedge mclk);
        rst_n = 1;
        t_boot(); t_factory(); t_user(); t_chunk(); t_feature();
        close_out();
    end
    initial
    begin
        #(30000 * 25);
        fail_count++;
        close_out();
    end
endmodule : config_set_manager_tb_top
`default_nettype wire
